// File: src/vtuf_pkg.sv
// constants, register map and shared types of the video transfer / usb fifo block
// assumes a single 10 MHz clock domain and an asynchronous active-high reset

package vtuf_pkg;

  // ****************************************
  // register port
  // ****************************************
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  localparam logic [3:0] REG_CTRL       = 4'h0;
  localparam logic [3:0] REG_PKT_SIZE   = 4'h1;
  localparam logic [3:0] REG_START_THR  = 4'h2;
  localparam logic [3:0] REG_READ_GAP   = 4'h3;
  localparam logic [3:0] REG_STATUS     = 4'h4;
  localparam logic [3:0] REG_FRAME_INFO = 4'h5;

  // video_control_reg0 field positions
  localparam int unsigned CTRL_ACTIVE_BIT   = 0;
  localparam int unsigned CTRL_SYNC_BIT     = 1;
  localparam int unsigned CTRL_COMPRESS_BIT = 2;
  localparam int unsigned CTRL_FMT422_BIT   = 3;

  localparam logic [15:0] CTRL_RST      = 16'h0000;
  localparam logic [15:0] PKT_SIZE_RST  = 16'h0100;
  localparam logic [15:0] START_THR_RST = 16'h0040;
  localparam logic [15:0] READ_GAP_RST  = 16'h0008;

  // ****************************************
  // stream format
  // ****************************************
  localparam logic [7:0]  SYNC_BYTE0  = 8'h00;
  localparam logic [7:0]  SYNC_BYTE1  = 8'hff;
  localparam int unsigned FRAME_CNT_W = 7;
  localparam int unsigned LINE_CNT_W  = 9;

  // byte slots of one group: 0-3 sync, 4-7 luma, 8-11 chroma
  localparam logic [3:0] SLOT_SYNC0   = 4'h0;
  localparam logic [3:0] SLOT_LUMA0   = 4'h4;
  localparam logic [3:0] SLOT_LAST_C  = 4'h7;
  localparam logic [3:0] SLOT_LAST420 = 4'h9;
  localparam logic [3:0] SLOT_LAST422 = 4'hb;

  // ****************************************
  // fifo and timing
  // ****************************************
  localparam int unsigned FIFO_AW    = 8;
  localparam int unsigned FIFO_DEPTH = 256;
  localparam int unsigned ENTRY_W    = 9;

  localparam int unsigned USB_FRAME_NS       = 1000000;
  localparam int unsigned CLK_PERIOD_NS      = 100;
  localparam int unsigned USB_FRAME_CYCLES_D = USB_FRAME_NS / CLK_PERIOD_NS;
  localparam int unsigned READ_CLK_MHZ       = 12;
  localparam int unsigned CLK_MHZ            = 10;
  localparam logic [4:0]  TICK_ADD           = 5'(READ_CLK_MHZ);
  localparam logic [4:0]  TICK_SUB           = 5'(CLK_MHZ);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_CLOSE = 3'b100
  } vtuf_state_e;

endpackage : vtuf_pkg

// File: src/vtuf_fifo.sv
// video fifo: flip-flop storage of bytes tagged with a frame-start bit
// assumes first-word-fall-through reads; clear empties it in one cycle

module vtuf_fifo
  import vtuf_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               clr,
  // write side
  input  wire logic               wr_valid,
  input  wire logic [ENTRY_W-1:0] wr_data,
  output logic                    wr_ready,
  // read side
  input  wire logic               rd_en,
  output logic      [ENTRY_W-1:0] rd_data,
  output logic                    empty,
  output logic      [FIFO_AW:0]   level
);

  typedef struct packed {
    logic [FIFO_DEPTH-1:0][ENTRY_W-1:0] mem;
    logic [FIFO_AW-1:0]                 wp;
    logic [FIFO_AW-1:0]                 rp;
    logic [FIFO_AW:0]                   cnt;
  } vtuf_fifo_s;

  vtuf_fifo_s cur_q, nxt_d;
  logic       push;
  logic       pop;

  assign wr_ready = (cur_q.cnt != (FIFO_AW+1)'(FIFO_DEPTH));
  assign empty    = (cur_q.cnt == '0);
  assign rd_data  = cur_q.mem[cur_q.rp];
  assign level    = cur_q.cnt;

  always_comb begin
    nxt_d = cur_q;
    push  = wr_valid && wr_ready;
    pop   = rd_en && !empty;
    if (clr) begin
      nxt_d.wp  = '0;
      nxt_d.rp  = '0;
      nxt_d.cnt = '0;
    end else begin
      if (push) begin
        nxt_d.mem[cur_q.wp] = wr_data;
        nxt_d.wp            = cur_q.wp + 1'b1;
      end
      if (pop) begin
        nxt_d.rp = cur_q.rp + 1'b1;
      end
      if (push && !pop) begin
        nxt_d.cnt = cur_q.cnt + 1'b1;
      end else if (pop && !push) begin
        nxt_d.cnt = cur_q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_q <= '0;
    end else begin
      cur_q <= nxt_d;
    end
  end

endmodule : vtuf_fifo

// File: src/vtuf_xfer_fmt.sv
// transfer buffer: serialises one 4-pixel group per accept, adds in-band sync words
// assumes line_start on the first group of each line, frame_start on the first of a frame

module vtuf_xfer_fmt
  import vtuf_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // configuration
  input  wire logic                   active,
  input  wire logic                   sync_en,
  input  wire logic                   compress,
  input  wire logic                   fmt_422,
  // group input
  input  wire logic                   in_valid,
  input  wire logic                   in_frame_start,
  input  wire logic                   in_line_start,
  input  wire logic [31:0]            in_luma,
  input  wire logic [31:0]            in_chroma,
  output logic                        in_ready,
  // byte output
  output logic                        out_valid,
  output logic      [ENTRY_W-1:0]     out_entry,
  input  wire logic                   out_ready,
  output logic      [FRAME_CNT_W-1:0] frame_cnt
);

  typedef struct packed {
    logic                   rdy;
    logic                   busy;
    logic [3:0]             slot;
    logic [3:0]             last;
    logic [31:0]            luma;
    logic [31:0]            chroma;
    logic                   sof;
    logic [FRAME_CNT_W-1:0] fcnt;
    logic [LINE_CNT_W-1:0]  lcnt;
  } vtuf_fmt_s;

  vtuf_fmt_s  cur_q, nxt_d;
  logic [7:0] byte_v;
  logic       odd;

  assign in_ready  = cur_q.rdy;
  assign out_valid = cur_q.busy;
  assign out_entry = {cur_q.sof, byte_v};
  assign frame_cnt = cur_q.fcnt;
  assign odd       = cur_q.lcnt[0];

  always_comb begin
    case (cur_q.slot)
      4'h0:    byte_v = SYNC_BYTE0; // RULE3
      4'h1:    byte_v = SYNC_BYTE1; // RULE3
      4'h2:    byte_v = {cur_q.fcnt, cur_q.lcnt[8]}; // RULE3
      4'h3:    byte_v = cur_q.lcnt[7:0];
      4'h4:    byte_v = cur_q.luma[7:0];
      4'h5:    byte_v = cur_q.luma[15:8];
      4'h6:    byte_v = cur_q.luma[23:16];
      4'h7:    byte_v = cur_q.luma[31:24];
      // chroma lanes: u0, v0, u2, v2
      4'h8:    byte_v = (fmt_422 || !odd) ? cur_q.chroma[7:0] : cur_q.chroma[15:8]; // RULE5
      4'h9:    byte_v = fmt_422 ? cur_q.chroma[15:8]
                                : (odd ? cur_q.chroma[31:24] : cur_q.chroma[23:16]); // RULE5
      4'ha:    byte_v = cur_q.chroma[23:16]; // RULE6
      default: byte_v = cur_q.chroma[31:24]; // RULE6
    endcase
  end

  always_comb begin
    nxt_d = cur_q;
    if (cur_q.busy && out_ready) begin
      nxt_d.sof  = 1'b0;
      nxt_d.slot = cur_q.slot + 1'b1;
      if (cur_q.slot == cur_q.last) begin
        nxt_d.busy = 1'b0;
      end
    end
    if (in_valid && cur_q.rdy) begin
      nxt_d.busy   = 1'b1;
      nxt_d.luma   = in_luma;
      nxt_d.chroma = in_chroma;
      nxt_d.sof    = in_frame_start;
      // compressed bytes ride the luma lanes only
      nxt_d.last   = compress ? SLOT_LAST_C : (fmt_422 ? SLOT_LAST422 : SLOT_LAST420);
      // sync only at line start, only with the bit set, never when compressing
      nxt_d.slot   = (sync_en && !compress && in_line_start) ? SLOT_SYNC0 : SLOT_LUMA0; // RULE1 RULE2 RULE6
      if (in_frame_start) begin
        nxt_d.fcnt = cur_q.fcnt + 1'b1; // RULE4
        nxt_d.lcnt = '0;
      end else if (in_line_start) begin
        nxt_d.lcnt = cur_q.lcnt + 1'b1;
      end
    end
    nxt_d.rdy = active && !nxt_d.busy;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_q <= '0;
    end else begin
      cur_q <= nxt_d;
    end
  end

endmodule : vtuf_xfer_fmt

// File: src/vtuf_top.sv
// video transfer path: transfer buffer, video fifo and usb packet engine read side
// assumes one 10 MHz clock, a register master on a plain strobe port and a packet
// sink that takes one byte per data strobe without back-pressure
//
// Behaviour
// RULE1: sync words are inserted only while sync_insert_enable is set.
// RULE2: sync words are only for uncompressed streams, never with compression.
// RULE3: sync word is 00, ff, then 7-bit frame count over 9-bit line count.
// RULE4: frame counter steps once per frame and wraps around.
// RULE5: 4:2:0 groups are four luma then two chroma, u even lines, v odd.
// RULE6: 4:2:2 groups are four luma then u0 v0 u2 v2, sync at line start.
// RULE7: a frame goes out as equal packets, the final one always shorter.
// RULE8: zero-length packets may separate frames, always present at low frame rates.
// RULE9: packet-length setting gives the size of every non-final packet.
// RULE10: a new frame is not read until start-threshold bytes are written.
// RULE11: successive fifo reads are spaced by the read gap in 12 MHz cycles.
// RULE12: the fifo works only while its activation bit is set.
// RULE13: only the transfer buffer writes the fifo; writes have no settings.
// RULE14: every 1 ms interval the engine tries to read one packet length.
// RULE15: a read stops at another frame's bytes or when the fifo runs empty.
// RULE16: software keeps read gap below 12000 over packet length.
// RULE17: software reprograms length, threshold and gap on every mode change.
// RULE18: an interval without eligible data sends a zero-length packet.
// RULE19: the controller selects a register space before accessing its data.
//
// The address-and-strobe port and the register offsets were left to the implementer.

module vtuf_top
  import vtuf_pkg::*;
#(
  parameter int unsigned USB_FRAME_CYCLES = USB_FRAME_CYCLES_D
)
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // video groups from the formatting pipeline
  input  wire logic              vid_valid,
  input  wire logic              vid_frame_start,
  input  wire logic              vid_line_start,
  input  wire logic [31:0]       vid_luma,
  input  wire logic [31:0]       vid_chroma,
  output logic                   vid_ready,
  // isochronous packet stream
  output logic                   pkt_start,
  output logic                   pkt_end,
  output logic                   pkt_data_valid,
  output logic      [7:0]        pkt_data,
  output logic      [15:0]       pkt_len
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    vtuf_state_e st;
    logic [15:0] ctrl;
    logic [15:0] pkt_size;
    logic [15:0] start_thr;
    logic [15:0] read_gap;
    logic [15:0] rdata;
    logic [15:0] ivl_cnt;
    logic        due;
    logic [4:0]  tick_acc;
    logic [15:0] gap_cnt;
    logic [15:0] byte_cnt;
    logic        last_full;
    logic        pstart;
    logic        pend;
    logic        dvalid;
    logic [7:0]  data;
    logic [15:0] len;
  } vtuf_top_s;

  vtuf_top_s cur_q, nxt_d;

  logic                   active;
  logic                   fmt_valid;
  logic [ENTRY_W-1:0]     fmt_entry;
  logic                   fifo_ready;
  logic                   pop;
  logic [ENTRY_W-1:0]     head;
  logic                   fifo_empty;
  logic [FIFO_AW:0]       fifo_level;
  logic [FRAME_CNT_W-1:0] frame_cnt;
  logic                   vid_ready_w;
  logic                   head_sof;
  logic                   eligible;
  logic                   tick;
  logic [4:0]             acc_sum;

  assign active   = cur_q.ctrl[CTRL_ACTIVE_BIT];
  assign head_sof = head[ENTRY_W-1];

  // ****************************************
  // transfer buffer and fifo
  // ****************************************
  vtuf_xfer_fmt u_fmt (
    .clk            (clk),
    .rst            (rst),
    .active         (active),
    .sync_en        (cur_q.ctrl[CTRL_SYNC_BIT]),
    .compress       (cur_q.ctrl[CTRL_COMPRESS_BIT]),
    .fmt_422        (cur_q.ctrl[CTRL_FMT422_BIT]),
    .in_valid       (vid_valid),
    .in_frame_start (vid_frame_start),
    .in_line_start  (vid_line_start),
    .in_luma        (vid_luma),
    .in_chroma      (vid_chroma),
    .in_ready       (vid_ready_w),
    .out_valid      (fmt_valid),
    .out_entry      (fmt_entry),
    .out_ready      (fifo_ready),
    .frame_cnt      (frame_cnt)
  );

  // in_ready is a flop inside the formatter
  assign vid_ready = vid_ready_w;

  vtuf_fifo u_fifo (
    .clk      (clk),
    .rst      (rst),
    .clr      (!active), // RULE12
    .wr_valid (fmt_valid && active), // RULE13
    .wr_data  (fmt_entry),
    .wr_ready (fifo_ready),
    .rd_en    (pop),
    .rd_data  (head),
    .empty    (fifo_empty),
    .level    (fifo_level)
  );

  // ****************************************
  // read pacing
  // ****************************************
  // 12 MHz ticks made from the 10 MHz clock by a fractional accumulator;
  // one tick per clock, two when tick is high; the average rate is exact
  assign acc_sum = cur_q.tick_acc + TICK_ADD;
  assign tick    = (acc_sum >= 5'(2 * TICK_SUB));

  // a new frame at the head waits for the start threshold
  assign eligible = !fifo_empty
                    && (cur_q.pkt_size != '0)
                    && (!head_sof || ({7'h00, fifo_level} >= cur_q.start_thr)); // RULE10

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_d        = cur_q;
    pop          = 1'b0;
    nxt_d.pstart = 1'b0;
    nxt_d.pend   = 1'b0;
    nxt_d.dvalid = 1'b0;
    nxt_d.rdata  = '0;

    // register writes
    if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        nxt_d.ctrl = {12'h000, reg_wdata[3:0]};
      end else if (reg_addr == REG_PKT_SIZE) begin
        nxt_d.pkt_size = reg_wdata;
      end else if (reg_addr == REG_START_THR) begin
        nxt_d.start_thr = reg_wdata;
      end else if (reg_addr == REG_READ_GAP) begin
        nxt_d.read_gap = reg_wdata;
      end
    end

    // register reads, answered next cycle; unmapped reads give zero
    if (reg_rd) begin
      if (reg_addr == REG_CTRL) begin
        nxt_d.rdata = cur_q.ctrl;
      end else if (reg_addr == REG_PKT_SIZE) begin
        nxt_d.rdata = cur_q.pkt_size;
      end else if (reg_addr == REG_START_THR) begin
        nxt_d.rdata = cur_q.start_thr;
      end else if (reg_addr == REG_READ_GAP) begin
        nxt_d.rdata = cur_q.read_gap;
      end else if (reg_addr == REG_STATUS) begin
        nxt_d.rdata = {cur_q.st == ST_READ, cur_q.last_full, fifo_empty, 4'h0, fifo_level};
      end else if (reg_addr == REG_FRAME_INFO) begin
        nxt_d.rdata = {9'h000, frame_cnt};
      end
    end

    // usb frame interval
    if (cur_q.ivl_cnt == 16'(USB_FRAME_CYCLES - 1)) begin
      nxt_d.ivl_cnt = '0;
      nxt_d.due     = active; // RULE14
    end else begin
      nxt_d.ivl_cnt = cur_q.ivl_cnt + 1'b1;
    end

    nxt_d.tick_acc = tick ? (acc_sum - 5'(2 * TICK_SUB)) : (acc_sum - TICK_SUB);
    if (cur_q.gap_cnt != '0) begin
      nxt_d.gap_cnt = cur_q.gap_cnt - 16'h1 - 16'(tick && cur_q.gap_cnt != 16'h1); // RULE11
    end

    case (cur_q.st)
      ST_IDLE: begin
        if (cur_q.due && active) begin
          nxt_d.due    = 1'b0;
          nxt_d.pstart = 1'b1;
          nxt_d.len    = '0;
          if (eligible && !(head_sof && cur_q.last_full)) begin
            nxt_d.st       = ST_READ;
            nxt_d.byte_cnt = '0;
            nxt_d.gap_cnt  = '0;
          end else begin
            // no eligible bytes: empty packet, never stale data
            nxt_d.pend = 1'b1; // RULE18 RULE8
            // a full last packet is followed by this empty one as the short end
            if (head_sof && !fifo_empty) begin
              nxt_d.last_full = 1'b0; // RULE7
            end
          end
        end
      end

      ST_READ: begin
        if (!active) begin
          nxt_d.st = ST_CLOSE;
        end else if (fifo_empty || (cur_q.byte_cnt != '0 && head_sof)) begin
          // pointer caught up or next byte belongs to another frame
          nxt_d.st        = ST_CLOSE; // RULE15
          nxt_d.last_full = 1'b0;
        end else if (cur_q.gap_cnt == '0) begin
          pop            = 1'b1;
          nxt_d.dvalid   = 1'b1;
          nxt_d.data     = head[7:0];
          nxt_d.byte_cnt = cur_q.byte_cnt + 1'b1;
          nxt_d.len      = cur_q.byte_cnt + 1'b1;
          nxt_d.gap_cnt  = cur_q.read_gap; // RULE11
          if (cur_q.byte_cnt + 1'b1 == cur_q.pkt_size) begin
            // full packet; remember it so a frame end right here gets an empty tail
            nxt_d.st        = ST_CLOSE; // RULE9
            nxt_d.last_full = 1'b1; // RULE7
          end
        end
      end

      ST_CLOSE: begin
        nxt_d.pend = 1'b1;
        nxt_d.st   = ST_IDLE;
      end

      default: begin
        nxt_d.st = ST_IDLE;
      end
    endcase

    if (!active) begin
      nxt_d.due       = 1'b0;
      nxt_d.last_full = 1'b0; // RULE12
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_q           <= '0;
      cur_q.st        <= ST_IDLE;
      cur_q.ctrl      <= CTRL_RST;
      cur_q.pkt_size  <= PKT_SIZE_RST;
      cur_q.start_thr <= START_THR_RST;
      cur_q.read_gap  <= READ_GAP_RST;
    end else begin
      cur_q <= nxt_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata      = cur_q.rdata;
  assign pkt_start      = cur_q.pstart;
  assign pkt_end        = cur_q.pend;
  assign pkt_data_valid = cur_q.dvalid;
  assign pkt_data       = cur_q.data;
  assign pkt_len        = cur_q.len;

endmodule : vtuf_top

// File: verification/vtuf_top_properties.sv
// checker: packet stream, video handshake
// assumes it is bound onto vtuf_top
module vtuf_top_properties
  import vtuf_pkg::*;
#(
  parameter int unsigned USB_FRAME_CYCLES = USB_FRAME_CYCLES_D
)
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // video side
  input wire logic        vid_valid,
  input wire logic        vid_ready,
  // packet stream
  input wire logic        pkt_start,
  input wire logic        pkt_end,
  input wire logic        pkt_data_valid,
  input wire logic [15:0] pkt_len
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // packet framing tracker
  // ****
  logic in_pkt_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_pkt_q <= 1'b0;
    end else if (pkt_start) begin
      in_pkt_q <= !pkt_end;
    end else if (pkt_end) begin
      in_pkt_q <= 1'b0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  start_pulse_a: assert property (pkt_start |=> !pkt_start)
    else $error("pkt_start wider than one cycle");
  end_pulse_a: assert property (pkt_end |=> !pkt_end)
    else $error("pkt_end wider than one cycle");
  first_byte_a: assert property (pkt_start && !pkt_end |=> pkt_data_valid || pkt_end)
    else $error("no byte or end after pkt_start");
  zlp_len_a: assert property (pkt_start && pkt_end |-> pkt_len == 16'h0)
    else $error("empty packet with nonzero length");
  len_first_a: assert property ($past(pkt_start) && pkt_data_valid |-> pkt_len == 16'h1)
    else $error("first byte count not one");
  len_step_a: assert property (pkt_data_valid && !$past(pkt_start) |->
    pkt_len == $past(pkt_len) + 16'h1)
    else $error("byte count did not step");
  len_hold_a: assert property (!pkt_data_valid && !pkt_start && !$past(pkt_start) |->
    $stable(pkt_len))
    else $error("byte count moved without a byte");
  byte_in_pkt_a: assert property (pkt_data_valid |-> in_pkt_q && !pkt_end)
    else $error("byte outside a packet");
  no_nest_a: assert property (pkt_start |-> !in_pkt_q)
    else $error("packet started inside a packet");
  group_hold_a: assert property (vid_valid && vid_ready |=> !vid_ready [*4])
    else $error("group taken before its bytes were written");
endmodule : vtuf_top_properties

bind vtuf_top vtuf_top_properties #(.USB_FRAME_CYCLES(USB_FRAME_CYCLES)) i_vtuf_top_properties (
  .clk(clk), .rst(rst), .vid_valid(vid_valid), .vid_ready(vid_ready), .pkt_start(pkt_start),
  .pkt_end(pkt_end), .pkt_data_valid(pkt_data_valid), .pkt_len(pkt_len));

// File: verification/vtuf_pkt_sink.sv
// packet sink standing in for the usb host side
// assumes the pulse-per-byte stream of vtuf_top; never stalls
module vtuf_pkt_sink
  import vtuf_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // packet stream
  input  wire logic        pkt_end,
  input  wire logic        pkt_data_valid,
  input  wire logic [7:0]  pkt_data,
  input  wire logic [15:0] pkt_len,
  // captured results
  output logic             got_byte,
  output logic      [7:0]  got_data,
  output logic             got_end,
  output logic      [15:0] got_len
);
  timeunit 1ns;
  timeprecision 1ns;
  // bytes are taken only with their strobe, as the host would
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      got_byte <= 1'b0;
      got_end  <= 1'b0;
      got_data <= 8'h0;
      got_len  <= 16'h0;
    end else begin
      got_byte <= pkt_data_valid;
      got_end  <= pkt_end;
      if (pkt_data_valid) begin
        got_data <= pkt_data;
      end
      if (pkt_end) begin
        got_len <= pkt_len;
      end
    end
  end
endmodule : vtuf_pkt_sink

// File: verification/tb_top.sv
// testbench: register port, three frames of video, packet checks
// assumes vtuf_top with a 200-cycle usb interval
module tb_top
  import vtuf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, reg_wr, reg_rd, vid_valid, vid_fs, vid_ls, vid_ready;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, pkt_len, got_len, ctrl, field;
  logic [31:0] vid_luma, vid_chroma;
  logic        pkt_start, pkt_end, pkt_dv, got_byte, got_end;
  logic [7:0]  pkt_data, got_data;
  logic [6:0]  fcnt;
  logic [8:0]  line;
  logic [7:0]  byte_q[$];
  logic [15:0] len_q[$], rd_q[$], mask_q[$];
  int          err_count, n_checks, cyc, fed, gap_min, last_cyc, zlp_cnt, i;
  bit          chk_thr, rd_pend;
  integer      seed = 32'hd8aa;

  vtuf_top #(.USB_FRAME_CYCLES(200)) i_vtuf_top (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .vid_valid(vid_valid), .vid_frame_start(vid_fs), .vid_line_start(vid_ls),
    .vid_luma(vid_luma), .vid_chroma(vid_chroma), .vid_ready(vid_ready),
    .pkt_start(pkt_start), .pkt_end(pkt_end), .pkt_data_valid(pkt_dv),
    .pkt_data(pkt_data), .pkt_len(pkt_len));
  vtuf_pkt_sink i_vtuf_pkt_sink (.clk(clk), .rst(rst), .pkt_end(pkt_end),
    .pkt_data_valid(pkt_dv), .pkt_data(pkt_data), .pkt_len(pkt_len), .got_byte(got_byte),
    .got_data(got_data), .got_end(got_end), .got_len(got_len));

  always #50 clk = ~clk;

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a == REG_CTRL) ctrl = d;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    rd_q.push_back(e & m);
    mask_q.push_back(m);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : reg_read

  // expected bytes are queued before the group is offered
  task automatic send_group(input logic fs, input logic ls);
    logic [31:0] y, c;
    bit          raw;
    y   = $random(seed);
    c   = $random(seed);
    raw = !ctrl[CTRL_COMPRESS_BIT];
    if (fs) line = 9'h0;
    else if (ls) line++;
    if (fs) fcnt++;
    if (ls && raw && ctrl[CTRL_SYNC_BIT]) begin
      field = {fcnt, line};
      byte_q.push_back(SYNC_BYTE0);
      byte_q.push_back(SYNC_BYTE1);
      byte_q.push_back(field[15:8]);
      byte_q.push_back(field[7:0]);
    end
    for (int k = 0; k < 4; k++) byte_q.push_back(y[8*k +: 8]);
    if (raw && ctrl[CTRL_FMT422_BIT]) begin
      for (int k = 0; k < 4; k++) byte_q.push_back(c[8*k +: 8]);
    end else if (raw) begin
      byte_q.push_back(c[8*line[0] +: 8]);
      byte_q.push_back(c[16+8*line[0] +: 8]);
    end
    @(posedge clk);
    vid_valid  <= 1'b1;
    vid_fs     <= fs;
    vid_ls     <= ls;
    vid_luma   <= y;
    vid_chroma <= c;
    for (int k = 0; k < 50; k++) begin
      @(posedge clk);
      if (vid_ready === 1'b1) break;
    end
    fed++;
    vid_valid <= 1'b0;
  endtask : send_group

  task automatic wait_drain();
    for (int k = 0; k < 3000 && len_q.size() > 0; k++) @(posedge clk);
    check("packets outstanding", 16'h0, 16'(len_q.size()));
  endtask : wait_drain

  // ****
  // result monitor
  // ****
  always @(posedge clk) begin
    if (rd_pend) check("reg_rdata", rd_q.pop_front(), reg_rdata & mask_q.pop_front());
    rd_pend = reg_rd;
    if (got_byte === 1'b1) begin
      if (chk_thr) check("groups written before read", 16'h2, 16'(fed));
      chk_thr = 0;
      if (last_cyc >= 0) check("read spacing", 16'h1, 16'(cyc - last_cyc >= gap_min));
      last_cyc = cyc;
      check("pkt_data", {8'h0, byte_q.pop_front()}, {8'h0, got_data});
    end
    if (got_end === 1'b1) begin
      last_cyc = -1;
      if (got_len === 16'h0) zlp_cnt++;
      else check("pkt_len", len_q.pop_front(), got_len);
    end
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    {clk, reg_wr, reg_rd, vid_valid, vid_fs, vid_ls} = '0;
    {reg_addr, reg_wdata, vid_luma, vid_chroma, ctrl, fcnt, line} = '0;
    rst      = 1'b1;
    last_cyc = -1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    reg_read(REG_CTRL, CTRL_RST, 16'hffff);
    reg_read(REG_PKT_SIZE, PKT_SIZE_RST, 16'hffff);
    reg_read(REG_START_THR, START_THR_RST, 16'hffff);
    reg_read(REG_READ_GAP, READ_GAP_RST, 16'hffff);
    reg_write(4'hf, 16'h1234);
    reg_read(4'hf, 16'h0, 16'hffff);
    reg_write(REG_CTRL, 16'hfff0);
    reg_read(REG_CTRL, 16'h0, 16'hffff);
    $display("test reset_values done");
    reg_write(REG_PKT_SIZE, 16'h5);
    reg_write(REG_START_THR, 16'h14);
    reg_write(REG_READ_GAP, 16'h0);
    reg_write(REG_CTRL, 16'h3);
    gap_min = 0;
    chk_thr = 1;
    repeat (4) len_q.push_back(16'h5);
    send_group(1'b1, 1'b1);
    send_group(1'b0, 1'b1);
    wait_drain();
    zlp_cnt = 0;
    for (i = 0; i < 400 && zlp_cnt == 0; i++) @(posedge clk);
    check("empty packet after full end", 16'h1, 16'(zlp_cnt > 0));
    $display("test frame_420_sync done");
    reg_write(REG_START_THR, 16'h18);
    reg_write(REG_READ_GAP, 16'hc);
    reg_write(REG_CTRL, 16'h9);
    gap_min = 10;
    for (i = 0; i < 4; i++) len_q.push_back(16'h5);
    len_q.push_back(16'h4);
    send_group(1'b1, 1'b1);
    send_group(1'b0, 1'b1);
    send_group(1'b0, 1'b1);
    wait_drain();
    reg_read(REG_FRAME_INFO, 16'h2, 16'h007f);
    $display("test frame_422_gap done");
    reg_write(REG_START_THR, 16'h4);
    reg_write(REG_READ_GAP, 16'h0);
    reg_write(REG_CTRL, 16'h7);
    gap_min = 0;
    len_q.push_back(16'h4);
    send_group(1'b1, 1'b1);
    wait_drain();
    reg_read(REG_FRAME_INFO, 16'h3, 16'h007f);
    $display("test frame_compressed done");
    reg_write(REG_CTRL, 16'h0);
    reg_read(REG_STATUS, 16'h2000, 16'h21ff);
    vid_valid <= 1'b1;
    repeat (8) begin
      @(posedge clk);
      check("vid_ready", 16'h0, {15'h0, vid_ready});
    end
    vid_valid <= 1'b0;
    repeat (4) @(posedge clk);
    $display("test disable done");
    final_report();
  end
endmodule : tb_top
